// File: hw/fsr_pkg.sv
package fsr_pkg;

  // ==========================================================================
  // Widths and clock
  localparam int FSR_AW          = 24;
  localparam int FSR_DW          = 16;
  localparam int FSR_CLK_NS      = 40;
  localparam int FSR_SYNC_STAGES = 2;

  // ==========================================================================
  // Pin timing, in ns, and derived cycle counts (least times round up)
  localparam int FSR_T_ACC_NS   = 70;
  localparam int FSR_T_WP_NS    = 35;
  localparam int FSR_T_RP_NS    = 500;
  localparam int FSR_T_READY_NS = 20000;
  localparam logic [15:0] FSR_RD_CYC = 16'((FSR_T_ACC_NS + FSR_CLK_NS - 1)
                                           / FSR_CLK_NS + FSR_SYNC_STAGES);
  localparam logic [15:0] FSR_WP_CYC = 16'((FSR_T_WP_NS + FSR_CLK_NS - 1)
                                           / FSR_CLK_NS);
  localparam logic [15:0] FSR_RP_CYC = 16'((FSR_T_RP_NS + FSR_CLK_NS - 1)
                                           / FSR_CLK_NS);
  localparam logic [15:0] FSR_READY_CYC = 16'((FSR_T_READY_NS
                                              + FSR_CLK_NS - 1) / FSR_CLK_NS);

  // ==========================================================================
  // Register word indices (byte address = 4 * index)
  localparam logic [2:0] FSR_IDX_CMD    = 3'h0;
  localparam logic [2:0] FSR_IDX_ADDR   = 3'h1;
  localparam logic [2:0] FSR_IDX_DATA   = 3'h2;
  localparam logic [2:0] FSR_IDX_STATUS = 3'h3;
  localparam logic [2:0] FSR_IDX_RDATA  = 3'h4;

  // Status register flag positions
  localparam int FSR_ST_BUSY    = 0;
  localparam int FSR_ST_DONE    = 1;
  localparam int FSR_ST_FAIL    = 2;
  localparam int FSR_ST_TMO     = 3;
  localparam int FSR_ST_ABT     = 4;
  localparam int FSR_ST_RDY     = 5;
  localparam int FSR_ST_RESTART = 6;

  // Flash status word bit positions
  localparam int FSR_B_POLL  = 7;
  localparam int FSR_B_TOG1  = 6;
  localparam int FSR_B_TMO   = 5;
  localparam int FSR_B_ERASE = 3;
  localparam int FSR_B_TOG2  = 2;
  localparam int FSR_B_ABT   = 1;

  // Flash command words
  localparam logic [FSR_DW-1:0] FSR_CMD_RESET = 16'h00f0;
  localparam logic [FSR_DW-1:0] FSR_CMD_UNL1  = 16'h00aa;
  localparam logic [FSR_DW-1:0] FSR_CMD_UNL2  = 16'h0055;
  localparam logic [FSR_AW-1:0] FSR_ADR_UNL1  = 24'h000555;
  localparam logic [FSR_AW-1:0] FSR_ADR_UNL2  = 24'h0002aa;

  // ==========================================================================
  // Operations and states
  typedef enum logic [2:0] {
    FSR_OP_NONE   = 3'h0,
    FSR_OP_READ   = 3'h1,
    FSR_OP_WRITE  = 3'h2,
    FSR_OP_TOGGLE = 3'h3,
    FSR_OP_DPOLL  = 3'h4,
    FSR_OP_SWRST  = 3'h5,
    FSR_OP_ABRST  = 3'h6,
    FSR_OP_HWRST  = 3'h7
  } fsr_op_t;

  typedef enum logic [7:0] {
    FSR_S_IDLE  = 8'h01,
    FSR_S_WRSU  = 8'h02,
    FSR_S_WRPL  = 8'h04,
    FSR_S_WRHD  = 8'h08,
    FSR_S_RD    = 8'h10,
    FSR_S_EVAL  = 8'h20,
    FSR_S_RSTLO = 8'h40,
    FSR_S_RSTRC = 8'h80
  } fsr_state_t;

  // Whole controller state
  typedef struct packed {
    fsr_state_t        st;
    fsr_op_t           op;
    logic [15:0]       cnt;
    logic [1:0]        seq;
    logic              first;
    logic              recheck;
    logic              final_rd;
    logic              cancel;
    logic              prev_tog;
    logic [FSR_AW-1:0] cfg_addr;
    logic [FSR_DW-1:0] cfg_data;
    logic [FSR_DW-1:0] rdata;
    logic [FSR_DW-1:0] last_status;
    logic              busy;
    logic              done;
    logic              fail;
    logic              tmo;
    logic              abt;
    logic              restart;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              fl_reset_n;
    logic [FSR_AW-1:0] pin_addr;
    logic [FSR_DW-1:0] dq_out;
    logic              dq_oe;
    logic              dph_wr;
    logic [2:0]        dph_idx;
    logic [31:0]       hrdata;
    logic              hready;
  } fsr_regs_t;

endpackage : fsr_pkg

// File: hw/fsr_sync.sv
`timescale 1ns/10ps
`default_nettype none

module fsr_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // ==========================================================================
  // Two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;

endmodule : fsr_sync

`default_nettype wire

// File: hw/fsr_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module fsr_ctrl
  import fsr_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  output logic [FSR_AW-1:0]      flash_addr,
  input  wire logic [FSR_DW-1:0] flash_dq_in,
  output logic [FSR_DW-1:0]      flash_dq_out,
  output logic                   flash_dq_oe,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic                   flash_reset_n,
  input  wire logic              ready_busy_out_n
);

  fsr_regs_t         state_r;
  fsr_regs_t         state_nxt;
  logic [FSR_DW-1:0] dq_sync;
  logic              rb_sync_n;
  logic              rb_busy;
  logic [FSR_AW+FSR_DW-1:0] ab_first;
  logic [FSR_AW+FSR_DW-1:0] ab_next;
  logic              addr_ph;
  logic              word_ok;

  // ==========================================================================
  // Pin synchronisers: the flash has no clock, so every input is async.
  // Busy is synced active high so the reset value matches the idle pin.
  fsr_sync #(
    .W (FSR_DW + 1)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({~ready_busy_out_n, flash_dq_in}),
    .q     ({rb_busy, dq_sync})
  );

  assign rb_sync_n = ~rb_busy;

  // ==========================================================================
  // Helpers
  // Start one read cycle at the configured address; poll reads never move
  function automatic fsr_regs_t go_read(input fsr_regs_t x);
    fsr_regs_t y;
    y          = x;
    y.st       = FSR_S_RD;
    y.ce_n     = 1'b0;
    y.oe_n     = 1'b0;
    y.we_n     = 1'b1;
    y.dq_oe    = 1'b0;
    y.pin_addr = x.cfg_addr;
    y.cnt      = FSR_RD_CYC - 16'h1;
    return y;
  endfunction : go_read

  // Start one command write with output strobe held high
  function automatic fsr_regs_t go_write(input fsr_regs_t x,
                                         input logic [FSR_AW-1:0] a,
                                         input logic [FSR_DW-1:0] d);
    fsr_regs_t y;
    y          = x;
    y.st       = FSR_S_WRSU;
    y.ce_n     = 1'b0;
    y.oe_n     = 1'b1;
    y.we_n     = 1'b1;
    y.pin_addr = a;
    y.dq_out   = d;
    y.dq_oe    = 1'b1;
    return y;
  endfunction : go_write

  // Return to idle and report completion
  function automatic fsr_regs_t finish(input fsr_regs_t x);
    fsr_regs_t y;
    y       = x;
    y.st    = FSR_S_IDLE;
    y.busy  = 1'b0;
    y.done  = 1'b1;
    y.ce_n  = 1'b1;
    y.oe_n  = 1'b1;
    y.we_n  = 1'b1;
    y.dq_oe = 1'b0;
    y.cancel = 1'b0;
    return y;
  endfunction : finish

  // Abort-reset sequence: two unlock cycles, then the reset command
  function automatic logic [FSR_AW+FSR_DW-1:0] abrst_step(
    input logic [1:0] idx);
    case (idx)
      2'h0:    abrst_step = {FSR_ADR_UNL1, FSR_CMD_UNL1};
      2'h1:    abrst_step = {FSR_ADR_UNL2, FSR_CMD_UNL2};
      default: abrst_step = {FSR_ADR_UNL1, FSR_CMD_RESET};
    endcase
  endfunction : abrst_step

  // Register read view
  function automatic logic [31:0] reg_read(input fsr_regs_t x,
                                           input logic [2:0] idx,
                                           input logic rdy);
    logic [15:0] fl;
    fl                 = '0;
    fl[FSR_ST_BUSY]    = x.busy;
    fl[FSR_ST_DONE]    = x.done;
    fl[FSR_ST_FAIL]    = x.fail;
    fl[FSR_ST_TMO]     = x.tmo;
    fl[FSR_ST_ABT]     = x.abt;
    fl[FSR_ST_RDY]     = rdy;
    fl[FSR_ST_RESTART] = x.restart;
    case (idx)
      FSR_IDX_CMD:    reg_read = {29'h0, x.op};
      FSR_IDX_ADDR:   reg_read = {8'h0, x.cfg_addr};
      FSR_IDX_DATA:   reg_read = {16'h0, x.cfg_data};
      FSR_IDX_STATUS: reg_read = {x.last_status, fl};
      FSR_IDX_RDATA:  reg_read = {16'h0, x.rdata};
      default:        reg_read = 32'h0;
    endcase
  endfunction : reg_read

  // ==========================================================================
  // Bus decode: single word transfers only, zero wait states
  assign addr_ph = hsel && htrans[1] && hready;
  assign word_ok = (hsize == 3'h2) && (haddr[31:5] == 27'h0);

  // Abort-reset steps as nets; a call result cannot be sliced
  assign ab_first = abrst_step(2'h0);
  assign ab_next  = abrst_step(state_r.seq + 2'h1);

  // ==========================================================================
  // Next-state logic: bus writes first so hardware flag sets win
  always_comb begin
    state_nxt        = state_r;
    state_nxt.hready = 1'b1;
    state_nxt.dph_wr = 1'b0;

    // Address phase: capture write target, answer reads from current state
    if (addr_ph) begin
      state_nxt.dph_wr  = hwrite && word_ok;
      state_nxt.dph_idx = haddr[4:2];
      state_nxt.hrdata  = (!hwrite && word_ok)
                          ? reg_read(state_r, haddr[4:2], ~rb_sync_n)
                          : 32'h0;
    end

    // Data phase of a write
    if (state_r.dph_wr) begin
      case (state_r.dph_idx)
        FSR_IDX_ADDR: begin
          if (!state_r.busy) begin
            state_nxt.cfg_addr = hwdata[FSR_AW-1:0];
          end
        end
        FSR_IDX_DATA: begin
          if (!state_r.busy) begin
            state_nxt.cfg_data = hwdata[FSR_DW-1:0];
          end
        end
        FSR_IDX_STATUS: begin
          // Write one to the done bit clears all completion flags
          if (hwdata[FSR_ST_DONE]) begin
            state_nxt.done    = 1'b0;
            state_nxt.fail    = 1'b0;
            state_nxt.tmo     = 1'b0;
            state_nxt.abt     = 1'b0;
            state_nxt.restart = 1'b0;
          end
        end
        FSR_IDX_CMD: begin
          if (state_r.busy) begin
            // Writing no-op while busy stops polling at the next read
            if (hwdata[2:0] == FSR_OP_NONE) begin
              state_nxt.cancel = 1'b1;
            end
          end else if (hwdata[2:0] != FSR_OP_NONE) begin
            state_nxt.op       = fsr_op_t'(hwdata[2:0]);
            state_nxt.busy     = 1'b1;
            state_nxt.done     = 1'b0;
            state_nxt.fail     = 1'b0;
            state_nxt.tmo      = 1'b0;
            state_nxt.abt      = 1'b0;
            state_nxt.first    = 1'b1;
            state_nxt.recheck  = 1'b0;
            state_nxt.final_rd = 1'b0;
            state_nxt.cancel   = 1'b0;
            state_nxt.seq      = 2'h0;
            case (fsr_op_t'(hwdata[2:0]))
              FSR_OP_WRITE: begin
                state_nxt = go_write(state_nxt, state_r.cfg_addr,
                                     state_r.cfg_data);
              end
              FSR_OP_SWRST: begin
                state_nxt = go_write(state_nxt, state_r.cfg_addr,
                                     FSR_CMD_RESET);
              end
              FSR_OP_ABRST: begin
                state_nxt = go_write(state_nxt,
                                     ab_first[FSR_AW+FSR_DW-1:FSR_DW],
                                     ab_first[FSR_DW-1:0]);
              end
              FSR_OP_HWRST: begin
                // Busy device at reset: the interrupted job needs a rerun
                state_nxt.restart    = ~rb_sync_n;
                state_nxt.st         = FSR_S_RSTLO;
                state_nxt.fl_reset_n = 1'b0;
                state_nxt.ce_n       = 1'b1;
                state_nxt.oe_n       = 1'b1;
                state_nxt.we_n       = 1'b1;
                state_nxt.dq_oe      = 1'b0;
                state_nxt.cnt        = FSR_RP_CYC - 16'h1;
              end
              default: begin
                state_nxt = go_read(state_nxt);
              end
            endcase
          end
        end
        default: begin
        end
      endcase
    end

    // Pin sequencer
    case (state_r.st)
      FSR_S_IDLE: begin
      end
      FSR_S_WRSU: begin
        // Address settled; falling write strobe latches it
        state_nxt.we_n = 1'b0;
        state_nxt.cnt  = FSR_WP_CYC - 16'h1;
        state_nxt.st   = FSR_S_WRPL;
      end
      FSR_S_WRPL: begin
        if (state_r.cnt == 16'h0) begin
          // Both strobes rise together; data is held one more cycle
          state_nxt.we_n = 1'b1;
          state_nxt.ce_n = 1'b1;
          state_nxt.st   = FSR_S_WRHD;
        end else begin
          state_nxt.cnt = state_r.cnt - 16'h1;
        end
      end
      FSR_S_WRHD: begin
        if (state_r.op == FSR_OP_ABRST && state_r.seq != 2'h2) begin
          state_nxt.seq = state_r.seq + 2'h1;
          state_nxt = go_write(state_nxt,
            ab_next[FSR_AW+FSR_DW-1:FSR_DW],
            ab_next[FSR_DW-1:0]);
        end else begin
          state_nxt = finish(state_nxt);
        end
      end
      FSR_S_RD: begin
        if (state_r.cnt == 16'h0) begin
          // Deassert both strobes so the next read is a fresh cycle
          state_nxt.ce_n  = 1'b1;
          state_nxt.oe_n  = 1'b1;
          state_nxt.rdata = dq_sync;
          state_nxt.st    = FSR_S_EVAL;
        end else begin
          state_nxt.cnt = state_r.cnt - 16'h1;
        end
      end
      FSR_S_EVAL: begin
        if (state_r.op == FSR_OP_READ || state_r.final_rd) begin
          state_nxt = finish(state_nxt);
        end else if (state_r.cancel) begin
          // Dropped check; a later command starts over from step one
          state_nxt      = finish(state_nxt);
          state_nxt.done = 1'b0;
        end else begin
          state_nxt.last_status = state_r.rdata;
          state_nxt.prev_tog    = state_r.rdata[FSR_B_TOG1];
          state_nxt.first       = 1'b0;
          if ((state_r.op == FSR_OP_TOGGLE && !state_r.first &&
               state_r.rdata[FSR_B_TOG1] == state_r.prev_tog) ||
              (state_r.op == FSR_OP_DPOLL &&
               state_r.rdata[FSR_B_POLL] ==
               state_r.cfg_data[FSR_B_POLL])) begin
            // Finished: one more read fetches true array contents
            state_nxt.final_rd = 1'b1;
            state_nxt = go_read(state_nxt);
          end else if (state_r.op == FSR_OP_TOGGLE && state_r.first) begin
            state_nxt = go_read(state_nxt);
          end else if (state_r.recheck) begin
            // Still running after timeout: failed, reset the device
            state_nxt.fail = 1'b1;
            state_nxt.tmo  = 1'b1;
            state_nxt.op   = FSR_OP_SWRST;
            state_nxt = go_write(state_nxt, state_r.cfg_addr,
                                 FSR_CMD_RESET);
          end else if (state_r.rdata[FSR_B_TMO]) begin
            // Bit may have stopped just as timeout rose: look again
            state_nxt.recheck = 1'b1;
            state_nxt = go_read(state_nxt);
          end else if (state_r.rdata[FSR_B_ABT]) begin
            // Plain reset would not work; software runs the abort reset
            state_nxt      = finish(state_nxt);
            state_nxt.fail = 1'b1;
            state_nxt.abt  = 1'b1;
          end else begin
            state_nxt = go_read(state_nxt);
          end
        end
      end
      FSR_S_RSTLO: begin
        if (state_r.cnt == 16'h0) begin
          state_nxt.fl_reset_n = 1'b1;
          state_nxt.cnt        = FSR_READY_CYC - 16'h1;
          state_nxt.st         = FSR_S_RSTRC;
        end else begin
          state_nxt.cnt = state_r.cnt - 16'h1;
        end
      end
      FSR_S_RSTRC: begin
        // No command until the device accepts them again
        if (state_r.cnt == 16'h0) begin
          state_nxt = finish(state_nxt);
        end else begin
          state_nxt.cnt = state_r.cnt - 16'h1;
        end
      end
      default: begin
        state_nxt = finish(state_nxt);
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r            <= '0;
      state_r.st         <= FSR_S_IDLE;
      state_r.ce_n       <= 1'b1;
      state_r.oe_n       <= 1'b1;
      state_r.we_n       <= 1'b1;
      state_r.fl_reset_n <= 1'b1;
      state_r.hready     <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Outputs, all but the tied-off hresp straight from the state register
  assign hreadyout     = state_r.hready;
  assign hrdata        = state_r.hrdata;
  assign hresp         = 1'b0;
  assign flash_addr    = state_r.pin_addr;
  assign flash_dq_out  = state_r.dq_out;
  assign flash_dq_oe   = state_r.dq_oe;
  assign flash_ce_n    = state_r.ce_n;
  assign flash_oe_n    = state_r.oe_n;
  assign flash_we_n    = state_r.we_n;
  assign flash_reset_n = state_r.fl_reset_n;

endmodule : fsr_ctrl

`default_nettype wire

// File: testbench/fsr_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Pin and bus timing watch
module fsr_ctrl_chk
  import fsr_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              hreadyout,
  input wire logic [FSR_AW-1:0] flash_addr,
  input wire logic [FSR_DW-1:0] flash_dq_out,
  input wire logic              flash_dq_oe,
  input wire logic              flash_ce_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_we_n,
  input wire logic              flash_reset_n
);
  logic [15:0] lo_cnt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Reset pin low time, counted so the exact width can be checked
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lo_cnt <= 16'h0000;
    end else begin
      lo_cnt <= flash_reset_n ? 16'h0000 : lo_cnt + 16'h0001;
    end
  end

  sequence wr_pulse;
    $fell(flash_we_n) ##1 flash_we_n;
  endsequence
  sequence rd_strobe;
    (!flash_oe_n)[*4] ##1 flash_oe_n;
  endsequence

  a_zero_wait: assert property (hreadyout)
    else $error("wait state seen");
  a_cmd_strobes: assert property (
    !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
    else $error("bad write strobes");
  a_we_pulse: assert property ($fell(flash_we_n) |-> wr_pulse)
    else $error("write pulse width");
  a_data_hold: assert property (
    $rose(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_out) ##1 flash_we_n)
    else $error("data not held");
  a_rd_width: assert property ($fell(flash_oe_n) |-> rd_strobe)
    else $error("read strobe width");
  a_rd_quiet: assert property (
    !flash_oe_n |-> !flash_dq_oe && !flash_ce_n && flash_we_n)
    else $error("drive during read");
  a_rd_addr: assert property (
    !flash_oe_n && $past(flash_oe_n) == 1'b0 |-> $stable(flash_addr))
    else $error("address moved in read");
  a_rst_width: assert property ($rose(flash_reset_n) |-> lo_cnt == FSR_RP_CYC)
    else $error("reset pulse width");
endmodule : fsr_ctrl_chk

bind fsr_ctrl fsr_ctrl_chk chk_u (
  .clock(clock), .rst_n(rst_n), .hreadyout(hreadyout),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_reset_n(flash_reset_n)
);

`default_nettype wire

// File: testbench/fsr_flash_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Behavioural flash: status, commands, reset
module fsr_flash_model
  import fsr_pkg::*;
(
  input  wire logic [FSR_AW-1:0] flash_addr,
  output logic      [FSR_DW-1:0] flash_dq_in,
  input  wire logic [FSR_DW-1:0] flash_dq_out,
  input  wire logic              flash_ce_n,
  input  wire logic              flash_oe_n,
  input  wire logic              flash_we_n,
  input  wire logic              flash_reset_n,
  output logic                   ready_busy_out_n
);
  int                st   = 0; // 0 read, 1 busy, 2 timed out, 3 aborted
  int                left = 0;
  logic              tog  = 1'b0;
  logic [15:0]       arr  = 16'h0000;
  logic [15:0]       lastw = 16'h0000;
  logic [15:0]       wd   = 16'h0000;
  logic [15:0]       d1   = 16'h0000;
  logic [15:0]       d2   = 16'h0000;
  logic [FSR_AW-1:0] wa   = '0;
  logic [15:0]       stw;
  logic [15:0]       word;

  // Released bus shows the inverse of the last word, never a stale copy
  assign stw = {8'h00, ~arr[7], tog, st == 2, 3'b000, st == 3, 1'b0};
  assign word = (st != 0) ? stw : arr;
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n && flash_reset_n) ?
                       word : ~lastw;
  assign ready_busy_out_n = (st == 0);

  task automatic start(input int n, input int m, input logic [15:0] v);
    left = n;
    arr = v;
    st = (m == 0) ? 1 : m;
  endtask : start

  // End of a read: toggle and count down the embedded run
  always @(posedge flash_oe_n) begin
    lastw = word;
    if (st != 0) tog = ~tog;
    if (st == 1 && left > 0) left = left - 1;
    if (st == 1 && left == 0) st = 0;
  end

  // Address on the falling strobe, data on the rising one
  always @(negedge flash_we_n) wa = flash_addr;
  always @(posedge flash_we_n) begin
    wd = flash_dq_out;
    if (wd == 16'h00f0 && st == 2) st = 0;
    if (wd == 16'h00f0 && st == 3 && d1 == 16'h0055 && d2 == 16'h00aa) st = 0;
    d2 = d1;
    d1 = wd;
  end

  // Pin reset aborts whatever runs
  always @(negedge flash_reset_n) st = 0;
endmodule : fsr_flash_model

`default_nettype wire

// File: testbench/fsr_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Self-checking bench for the controller
module fsr_ctrl_tb
  import fsr_pkg::*;
;
  logic              clock, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0]       haddr, hwdata, hrdata, rv, a;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [FSR_AW-1:0] f_addr;
  logic [FSR_DW-1:0] dq_in, dq_out, v;
  logic              dq_oe, ce_n, oe_n, we_n, f_rst_n, rb_n;
  int                n_mismatch = 0, n_compared = 0, mm, e;
  int                exp_q[$];

  fsr_ctrl dut_u (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .flash_addr(f_addr), .flash_dq_in(dq_in),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(f_rst_n),
    .ready_busy_out_n(rb_n));
  fsr_flash_model flash_u (.flash_addr(f_addr), .flash_dq_in(dq_in),
    .flash_dq_out(dq_out), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_reset_n(f_rst_n), .ready_busy_out_n(rb_n));

  // Free-running bench clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        n_mismatch++;
        test_done();
      end
      @(posedge clock);
    end
  endtask : wait_rdy

  // One single word transfer; read data lands in rv
  task automatic ahb(input logic w, input logic [2:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {27'h0, i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
  endtask : ahb

  // Start an operation and poll status until done, bounded
  task automatic run(input logic [2:0] c);
    int k;
    k = 0;
    ahb(1'b1, 3'h0, {29'h0, c});
    ahb(1'b0, 3'h3, 32'h0);
    while (rv[1] !== 1'b1) begin
      k++;
      if (k > 3000) begin
        n_mismatch++;
        test_done();
      end
      ahb(1'b0, 3'h3, 32'h0);
    end
  endtask : run

  // Main sequence
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    v = 16'($urandom(97));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    ahb(1'b0, 3'h3, 32'h0);
    chk(rv, 32'h0);
    ahb(1'b0, 3'h7, 32'h0);
    chk(rv, 32'h0);
    a = {8'h00, 24'($urandom)};
    ahb(1'b1, 3'h1, a);
    ahb(1'b1, 3'h2, {16'h0, v});
    run(3'h2);
    chk(rv & 32'h5f, 32'h2);
    chk({8'h00, flash_u.wa}, a);
    chk({16'h0, flash_u.wd}, {16'h0, v});
    ahb(1'b1, 3'h3, 32'h2);
    // Toggle and data polls: success, timeout, buffer abort
    for (int m = 0; m < 6; m++) begin
      mm = (m < 2) ? 0 : m / 2 + 1;
      // Array words with bit 1 set would read as a buffer abort
      v = 16'($urandom) & 16'hfffd;
      exp_q.push_back(int'(v));
      flash_u.start(1 + $urandom % 5, mm, v);
      ahb(1'b1, 3'h2, {16'h0, v});
      run(3'h3 + 3'(m % 2));
      chk(rv & 32'h5f, (mm == 0) ? 32'h2 : (mm == 2) ? 32'he : 32'h16);
      e = exp_q.pop_front();
      ahb(1'b1, 3'h3, 32'h2);
      if (mm == 0) begin
        ahb(1'b0, 3'h4, 32'h0);
        chk(rv, 32'(e));
      end
      chk(32'(flash_u.st), (mm == 3) ? 32'd3 : 32'd0);
      if (mm == 3) begin
        run(3'h6);
        chk(32'(flash_u.st), 32'd0);
        ahb(1'b1, 3'h3, 32'h2);
      end
    end
    // Reset command and reset pulse while the device runs
    flash_u.start(100000, 0, v);
    repeat (FSR_SYNC_STAGES + 1) @(posedge clock);
    ahb(1'b0, 3'h3, 32'h0);
    chk({31'h0, rv[5]}, 32'h1);
    run(3'h5);
    chk(32'(flash_u.st), 32'd1);
    ahb(1'b1, 3'h3, 32'h2);
    run(3'h7);
    chk(rv & 32'h5f, 32'h42);
    chk(32'(flash_u.st), 32'd0);
    test_done();
  end
endmodule : fsr_ctrl_tb

`default_nettype wire
